// ---- pkg/apm_pkg.sv ----
package apm_pkg;
    localparam int WORD_BITS = 16;
    localparam int CTRL_BITS = 12;
    localparam int TRACK_EDGE = 14;
    localparam int WRITE_POS = 11;
    localparam int PM_HI_POS = 5;
    localparam int PM_LO_POS = 4;
    localparam logic [1:0] PM_NORMAL = 2'h3;
    localparam logic [1:0] PM_FULL_SD = 2'h2;
    localparam logic [1:0] PM_AUTO_SD = 2'h1;
    localparam logic [1:0] PM_RESET = 2'h3;
    localparam logic [11:0] CTRL_RESET = 12'h030;
    localparam int SYS_CLK_MHZ = 200;
    localparam int WAKE_TIME_NS = 1000;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int QUIET_TIME_NS = 50;
    localparam int QUIET_CYCLES = (QUIET_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int SCLK_HALF_DIV = 8;
    typedef enum logic [1:0] {APM_NORMAL, APM_FULL_SD, APM_AUTO_SD, APM_UNKNOWN} apm_mode_t;
endpackage

// ---- pkg/apm_link_if.sv ----
`timescale 1ns/10ps
interface apm_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout_o;
    logic dout_oe_n;
    logic dout;
    assign dout = dout_oe_n ? 1'b1 : dout_o;
    modport dev
    (
        input cs_n,
        input sclk,
        input din,
        output dout_o,
        output dout_oe_n
    );
    modport hst
    (
        output cs_n,
        output sclk,
        output din,
        input dout
    );
endinterface

// ---- logic/apm_dev.sv ----
`timescale 1ns/10ps
// Overview of operation
// R1 - Power-mode bits pick normal, full or auto
// R2 - Control word loads in first twelve clocks
// R3 - Write flag zero keeps power mode
// R4 - Host writes 1,1 each time for normal
// R5 - Sixteen clocks; track again on fourteenth fall
// R6 - Host restarts only after output idle, quiet
// R7 - Full shutdown retains register until rewritten
// R8 - Wake from full shutdown at select rise
// R9 - Host waits power-up before next select fall
// R10 - Auto mode sleeps after each conversion
// R11 - Auto sleep ends at select falling edge
// R12 - Host allows 1 us wake, dummy transfer
// R13 - Dummy wake transfer uses write flag zero
// R14 - Mode unknown at power-on; dummy transfers
// R15 - Normal after power-on: one all-ones dummy
// R16 - Update applies at select rise ending transfer
// R17 - Auto after power-on needs two dummies
// R18 - Write flag is first of twelve bits
// R19 - Early select rise aborts, discards update
// R20 - Mode held, unknown until first full write
module apm_dev
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link
    apm_link_if.dev link,
    // Status in system domain
    output logic [1:0] power_mode,
    output logic mode_known,
    output logic powered,
    output logic tracking,
    // Result word to shift out
    input wire logic [15:0] result_word
);
    ////////////////////////////////////////////////////////////////
    // Link domain, clocked by falling serial clock
    logic [4:0] cnt_ff, nxt_cnt;
    logic [11:0] shift_ff, nxt_shift;
    logic [15:0] out_ff, nxt_out;
    logic oe_n_ff, nxt_oe_n;
    logic track_ff, nxt_track;
    logic cs_d_ff;
    logic [4:0] cnt_at_fall;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_out = out_ff;
        nxt_oe_n = oe_n_ff;
        nxt_track = track_ff;
        if (link.cs_n)
        begin
            nxt_cnt = 5'h00;
            nxt_oe_n = 1'b1;
        end
        else
        begin
            if (cs_d_ff)
            begin
                nxt_cnt = 5'h01;
                nxt_out = {result_word[14:0], 1'b0};
                nxt_oe_n = 1'b0;
                nxt_shift = {shift_ff[10:0], link.din};
            end
            else if (cnt_ff < 5'(apm_pkg::WORD_BITS))
            begin
                nxt_cnt = cnt_ff + 5'h01;
                nxt_out = {out_ff[14:0], 1'b0};
                if (cnt_ff < 5'(apm_pkg::CTRL_BITS)) // R2 R18
                    nxt_shift = {shift_ff[10:0], link.din};
                if (cnt_ff + 5'h01 == 5'(apm_pkg::TRACK_EDGE)) // R5 R8
                    nxt_track = 1'b1;
                if (cnt_ff + 5'h01 == 5'(apm_pkg::WORD_BITS)) // R5
                    nxt_oe_n = 1'b1;
            end
            if (cs_d_ff)
                nxt_track = 1'b0;
        end
    end

    always_ff @(negedge link.sclk or posedge link.cs_n)
    begin
        if (link.cs_n)
            cs_d_ff <= 1'b1;
        else
            cs_d_ff <= 1'b0;
    end

    always_ff @(negedge link.sclk)
    begin
        cnt_ff <= nxt_cnt;
        shift_ff <= nxt_shift;
        out_ff <= nxt_out;
        oe_n_ff <= nxt_oe_n;
        track_ff <= nxt_track;
    end
    assign cnt_at_fall = cnt_ff;

    assign link.dout_o = cs_d_ff ? result_word[15] : out_ff[15];
    assign link.dout_oe_n = link.cs_n | (oe_n_ff & ~cs_d_ff); // R5 R19

    ////////////////////////////////////////////////////////////////
    // Transfer end captured at select rise
    logic done_tgl_ff, nxt_done_tgl;
    logic [11:0] word_ff, nxt_word;
    logic start_tgl_ff, nxt_start_tgl;

    always_comb
    begin
        nxt_done_tgl = done_tgl_ff;
        nxt_word = word_ff;
        if (cnt_at_fall == 5'(apm_pkg::WORD_BITS)) // R19
        begin
            nxt_done_tgl = ~done_tgl_ff;
            nxt_word = shift_ff;
        end
    end

    // Toggles cleared by system reset, else never known
    always_ff @(posedge link.cs_n or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            done_tgl_ff <= 1'b0;
            word_ff <= apm_pkg::CTRL_RESET;
        end
        else
        begin
            done_tgl_ff <= nxt_done_tgl; // R16
            word_ff <= nxt_word;
        end
    end

    assign nxt_start_tgl = ~start_tgl_ff;

    always_ff @(negedge link.cs_n or posedge sys_rst)
    begin
        if (sys_rst)
            start_tgl_ff <= 1'b0;
        else
            start_tgl_ff <= nxt_start_tgl; // R11
    end

    ////////////////////////////////////////////////////////////////
    // System domain: synchronisers and mode state
    logic [2:0] done_sync_ff;
    logic [2:0] start_sync_ff;
    logic [2:0] trk_sync_ff;
    logic [1:0] pm_ff, nxt_pm;
    logic known_ff, nxt_known;
    logic pwr_ff, nxt_pwr;
    logic trk_ff, nxt_trk;
    logic done_ev, start_ev;
    logic wr_ok;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            done_sync_ff <= 3'h0;
            start_sync_ff <= 3'h0;
            trk_sync_ff <= 3'h0;
        end
        else
        begin
            done_sync_ff <= {done_sync_ff[1:0], done_tgl_ff};
            start_sync_ff <= {start_sync_ff[1:0], start_tgl_ff};
            trk_sync_ff <= {trk_sync_ff[1:0], track_ff};
        end
    end

    assign done_ev = done_sync_ff[2] ^ done_sync_ff[1];
    assign start_ev = start_sync_ff[2] ^ start_sync_ff[1];
    assign wr_ok = word_ff[apm_pkg::WRITE_POS];

    always_comb
    begin
        nxt_pm = pm_ff;
        nxt_known = known_ff;
        nxt_pwr = pwr_ff;
        if (start_ev && pm_ff == apm_pkg::PM_AUTO_SD) // R11
            nxt_pwr = 1'b1;
        if (done_ev)
        begin
            if (wr_ok) // R2 R3
            begin
                nxt_pm = {word_ff[apm_pkg::PM_HI_POS], word_ff[apm_pkg::PM_LO_POS]}; // R20
                nxt_known = 1'b1;
            end
            case (nxt_pm) // R1
                apm_pkg::PM_NORMAL: nxt_pwr = 1'b1; // R8
                apm_pkg::PM_FULL_SD: nxt_pwr = 1'b0; // R7 R16
                apm_pkg::PM_AUTO_SD: nxt_pwr = 1'b0; // R10
                default: nxt_pwr = pwr_ff;
            endcase
        end
        nxt_trk = trk_sync_ff[2] & nxt_pwr; // R10
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pm_ff <= apm_pkg::PM_RESET;
            known_ff <= 1'b0;
            pwr_ff <= 1'b1;
            trk_ff <= 1'b0;
        end
        else
        begin
            pm_ff <= nxt_pm;
            known_ff <= nxt_known;
            pwr_ff <= nxt_pwr;
            trk_ff <= nxt_trk;
        end
    end

    assign power_mode = pm_ff;
    assign mode_known = known_ff; // R14
    assign powered = pwr_ff;
    assign tracking = trk_ff; // R10
endmodule

// ---- logic/apm_host.sv ----
`timescale 1ns/10ps
module apm_host
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link
    apm_link_if.hst link,
    // Command
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [11:0] req_ctrl,
    input wire logic req_wake,
    // Result
    output logic [15:0] rsp_data,
    output logic rsp_valid
);
    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_END, H_WAIT} apm_hst_t;
    apm_hst_t st_ff, nxt_st;
    logic [3:0] div_ff, nxt_div;
    logic [4:0] bit_ff, nxt_bit;
    logic [15:0] tx_ff, nxt_tx;
    logic [15:0] rx_ff, nxt_rx;
    logic [15:0] rsp_ff, nxt_rsp;
    logic rv_ff, nxt_rv;
    logic [7:0] wait_ff, nxt_wait;
    logic [1:0] dsync_ff;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            dsync_ff <= 2'h3;
        else
            dsync_ff <= {dsync_ff[0], link.dout};
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_div = div_ff;
        nxt_bit = bit_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_rsp = rsp_ff;
        nxt_rv = 1'b0;
        nxt_wait = wait_ff;
        case (st_ff)
            H_IDLE:
                if (req_valid)
                begin
                    nxt_tx = {req_ctrl, 4'h0};
                    nxt_wait = req_wake ? 8'(apm_pkg::WAKE_CYCLES) : 8'(apm_pkg::QUIET_CYCLES); // R9 R12 R15
                    nxt_st = H_HIGH;
                    nxt_div = 4'h0;
                    nxt_bit = 5'h00;
                end
            H_HIGH:
                if (div_ff == 4'(apm_pkg::SCLK_HALF_DIV - 1))
                begin
                    nxt_div = 4'h0;
                    nxt_st = H_LOW;
                    nxt_rx = {rx_ff[14:0], dsync_ff[1]};
                end
                else
                    nxt_div = div_ff + 4'h1;
            H_LOW:
                if (div_ff == 4'(apm_pkg::SCLK_HALF_DIV - 1))
                begin
                    nxt_div = 4'h0;
                    nxt_tx = {tx_ff[14:0], 1'b0};
                    nxt_bit = bit_ff + 5'h01;
                    nxt_st = (bit_ff == 5'(apm_pkg::WORD_BITS - 1)) ? H_END : H_HIGH; // R5
                end
                else
                    nxt_div = div_ff + 4'h1;
            H_END:
            begin
                nxt_rsp = rx_ff;
                nxt_rv = 1'b1;
                nxt_st = H_WAIT;
            end
            H_WAIT:
                if (wait_ff == 8'h00) // R6
                    nxt_st = H_IDLE;
                else
                    nxt_wait = wait_ff - 8'h01;
            default: nxt_st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_ff <= H_IDLE;
            div_ff <= 4'h0;
            bit_ff <= 5'h00;
            tx_ff <= 16'h0000;
            rx_ff <= 16'h0000;
            rsp_ff <= 16'h0000;
            rv_ff <= 1'b0;
            wait_ff <= 8'h00;
        end
        else
        begin
            st_ff <= nxt_st;
            div_ff <= nxt_div;
            bit_ff <= nxt_bit;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            rsp_ff <= nxt_rsp;
            rv_ff <= nxt_rv;
            wait_ff <= nxt_wait;
        end
    end

    assign req_ready = (st_ff == H_IDLE);
    assign link.cs_n = (st_ff == H_IDLE) || (st_ff == H_END) || (st_ff == H_WAIT);
    assign link.sclk = (st_ff != H_LOW);
    assign link.din = tx_ff[15]; // R4 R13 R17
    assign rsp_data = rsp_ff;
    assign rsp_valid = rv_ff;
endmodule

// ---- tb/apm_link_monitor.sv ----
`timescale 1ns/10ps
module apm_link_monitor
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_o,
    input wire logic dout_oe_n,
    input wire logic dout
);
    logic [4:0] falls_ff;
    logic [4:0] nxt_falls;
    logic sclk_d_ff;
    logic nxt_sclk_d;
    ////////////////////////////////////////////////////////////////
    // Falling clock edges within a frame
    always_comb
    begin
        nxt_sclk_d = sys_rst ? 1'b1 : sclk;
        nxt_falls = falls_ff;
        if (sys_rst || cs_n)
            nxt_falls = 5'h00;
        else if (sclk_d_ff && !sclk)
            nxt_falls = falls_ff + 5'h01;
    end
    always_ff @(posedge clk_sys)
    begin
        sclk_d_ff <= nxt_sclk_d;
        falls_ff <= nxt_falls;
    end
    ////////////////////////////////////////////////////////////////
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    a_frame_sixteen_falls: assert property ($rose(cs_n) |-> falls_ff == 5'h10)
        else $error("frame did not hold sixteen clock falls");
    a_quiet_gap: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("select lowered again too soon");
    a_idle_clock_high: assert property (cs_n && $past(cs_n) |-> sclk)
        else $error("serial clock not idle high");
    a_output_released: assert property (cs_n && $past(cs_n) |-> dout_oe_n && dout)
        else $error("output not released outside frame");
    a_output_driven: assert property ($fell(cs_n) |-> ##[0:4] !dout_oe_n)
        else $error("output not driven after select fall");
    a_frame_starts_high: assert property ($fell(cs_n) |-> sclk ##1 sclk)
        else $error("frame began with clock low");
    a_clock_low_phase: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("serial clock low phase too short");
    a_din_steady_high: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(din))
        else $error("serial input moved while clock high");
    c_frame_end: cover property ($rose(cs_n));
    c_frame_start: cover property ($fell(cs_n));
    c_write_frame: cover property ($fell(cs_n) && din);
endmodule

// ---- tb/adc_power_mode_control_tb.sv ----
`timescale 1ns/10ps
module adc_power_mode_control_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready;
    logic [11:0] req_ctrl = 12'h000;
    logic req_wake = 1'b0;
    logic [15:0] rsp_data;
    logic rsp_valid;
    logic [15:0] result_word = 16'h0000;
    logic [1:0] power_mode;
    logic [1:0] pm2;
    logic mode_known;
    logic powered;
    logic tracking;
    int miscompares = 0;
    int checked = 0;
    apm_link_if link ();
    apm_link_if link2 ();
    always #2.5 clk_sys = ~clk_sys;
    apm_dev apm_dev_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .power_mode(power_mode),
        .mode_known(mode_known), .powered(powered), .tracking(tracking), .result_word(result_word));
    apm_dev apm_dev_abort_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link2), .power_mode(pm2),
        .mode_known(), .powered(), .tracking(), .result_word(16'h0000));
    apm_host apm_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .req_valid(req_valid),
        .req_ready(req_ready), .req_ctrl(req_ctrl), .req_wake(req_wake), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid));
    apm_link_monitor apm_link_monitor_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(link.cs_n),
        .sclk(link.sclk), .din(link.din), .dout_o(link.dout_o), .dout_oe_n(link.dout_oe_n), .dout(link.dout));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return req_ready;
            1: return rsp_valid;
            default: return link.cs_n;
        endcase
    endfunction
    task automatic wait_lvl(input int sel, input logic v);
        for (int i = 0; i < 2000; i++)
        begin
            @(negedge clk_sys);
            if (pick(sel) === v)
                return;
        end
        miscompares++;
        wrap_up();
    endtask
    task automatic send(input logic [11:0] ctrl, input logic wake, input logic [15:0] res);
        wait_lvl(0, 1'b1);
        req_ctrl = ctrl;
        req_wake = wake;
        result_word = res;
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask
    task automatic done(input logic [15:0] res);
        wait_lvl(1, 1'b1);
        chk(rsp_data, res);
        repeat (20) @(negedge clk_sys);
    endtask
    task automatic xfer(input logic [11:0] ctrl, input logic wake, input logic [15:0] res,
        input logic [1:0] pm, input logic pwr);
        send(ctrl, wake, res);
        done(res);
        chk(16'(power_mode), 16'(pm));
        chk(16'(powered), 16'(pwr));
        chk(16'(tracking), 16'(pwr));
    endtask
    // Bench driven frame of n clocks, cut short when n is below sixteen
    task automatic bang(input logic [15:0] w, input int n);
        link2.cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            link2.din = w[15 - i];
            link2.sclk = 1'b1;
            repeat (16) @(negedge clk_sys);
            link2.sclk = 1'b0;
            repeat (16) @(negedge clk_sys);
        end
        link2.cs_n = 1'b1;
        link2.sclk = 1'b1;
        link2.din = ~link2.din;
        repeat (40) @(negedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        @(negedge clk_sys);
        link2.cs_n = 1'b1;
        link2.sclk = 1'b1;
        link2.din = 1'b0;
        repeat (7) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        chk(16'(mode_known), 16'h0000);
        xfer(12'h830, 1'b1, 16'h0ABC, apm_pkg::PM_NORMAL, 1'b1);
        chk(16'(mode_known), 16'h0001);
        xfer(12'h820, 1'b0, 16'h1234, apm_pkg::PM_FULL_SD, 1'b0);
        xfer(12'h030, 1'b0, 16'h2F0F, apm_pkg::PM_FULL_SD, 1'b0);
        xfer(12'h830, 1'b1, 16'h3A5A, apm_pkg::PM_NORMAL, 1'b1);
        xfer(12'h020, 1'b0, 16'h0F0F, apm_pkg::PM_NORMAL, 1'b1);
        xfer(12'h810, 1'b0, 16'h3C3C, apm_pkg::PM_AUTO_SD, 1'b0);
        send(12'h030, 1'b1, 16'h1357);
        wait_lvl(2, 1'b0);
        repeat (40) @(negedge clk_sys);
        chk(16'(powered), 16'h0001);
        done(16'h1357);
        chk(16'(power_mode), 16'(apm_pkg::PM_AUTO_SD));
        chk(16'(powered), 16'h0000);
        chk(16'(tracking), 16'h0000);
        bang(16'h8200, 16);
        chk(16'(pm2), 16'(apm_pkg::PM_FULL_SD));
        bang(16'h8300, 10);
        chk(16'(pm2), 16'(apm_pkg::PM_FULL_SD));
        bang(16'h0100, 16);
        chk(16'(pm2), 16'(apm_pkg::PM_FULL_SD));
        wrap_up();
    end
endmodule
